// ---- hdl/obcc_pkg.sv ----
/*
 * Constants, field layouts and types for the option byte clock configuration loader.
 * Assumes a single 100 MHz system clock and an Avalon-MM register slave with 32-bit data.
 */
package obcc_pkg;

	// ****************************************************************
	// Register byte addresses
	// ****************************************************************
	localparam logic [4:0] OBCC_ADDR_CLK_OPT = 5'h00;
	localparam logic [4:0] OBCC_ADDR_RSVD_OPT = 5'h04;
	localparam logic [4:0] OBCC_ADDR_PKG_OPT = 5'h08;
	localparam logic [4:0] OBCC_ADDR_STATUS = 5'h0c;

	// ****************************************************************
	// Field positions of the clock option byte
	// ****************************************************************
	localparam int OBCC_RESET_DELAY_SELECT = 7;
	localparam int OBCC_RANGE_MSB = 6;
	localparam int OBCC_RANGE_LSB = 4;
	localparam int OBCC_INTERNAL_RC_DISABLE = 3;
	localparam int OBCC_HALVING_DISABLE = 2;
	localparam int OBCC_MULTIPLIER_FACTOR_SELECT = 1;
	localparam int OBCC_MULTIPLIER_BYPASS = 0;

	// ****************************************************************
	// Field positions of the package option byte
	// ****************************************************************
	localparam int OBCC_PACKAGE_MSB = 7;
	localparam int OBCC_PACKAGE_LSB = 6;
	localparam int OBCC_TRIPLE_ADDRESS_SLAVE_SELECT = 5;
	localparam logic [4:0] OBCC_PKG_RSVD_ONES = 5'h1f;

	// ****************************************************************
	// Shipped contents and encodings
	// ****************************************************************
	localparam logic [7:0] OBCC_CLK_OPT_RESET = 8'hf7;
	localparam logic [7:0] OBCC_RSVD_OPT_RESET = 8'hff;
	localparam logic [7:0] OBCC_PKG_OPT_RESET = 8'hff;
	localparam logic [2:0] OBCC_RANGE_RSVD_A = 3'h4;
	localparam logic [2:0] OBCC_RANGE_RSVD_B = 3'h5;
	localparam logic [1:0] OBCC_PKG_32 = 2'h0;
	localparam logic [1:0] OBCC_PKG_44 = 2'h1;
	localparam logic [1:0] OBCC_PKG_48 = 2'h2;

	// ****************************************************************
	// Stabilisation counts in CPU cycles
	// ****************************************************************
	localparam int OBCC_CNT_W = 13;
	localparam logic [12:0] OBCC_STAB_LONG = 13'h1000;
	localparam logic [12:0] OBCC_STAB_SHORT = 13'h0100;

	// Decoded configuration, held from reset to reset.
	typedef struct packed {
		logic rc_on;
		logic resonator_en;
		logic [1:0] resonator_range;
		logic ext_clk;
		logic range_reserved;
		logic mult_en;
		logic mult_x8;
		logic halving_en;
		logic [1:0] package_code;
		logic slave3_en;
		logic combo_error;
	} obcc_cfg_t;

	typedef struct packed {
		logic [7:0] opt_clk;
		logic [7:0] opt_rsvd;
		logic [7:0] opt_pkg;
		logic prog_meta;
		logic prog_sync;
		logic waitreq;
		logic [31:0] rdata;
		obcc_cfg_t cfg;
		logic stab_long;
		logic [12:0] stab_cnt;
		logic stable;
	} obcc_state_t;

endpackage

// ---- hdl/obcc_loader.sv ----
/*
 * Option byte clock configuration loader: keeps the option bytes, decodes them at reset
 * and times the oscillator stabilisation after reset and after leaving Halt mode.
 * Assumes prog_mode comes from a pin, halt_exit from logic on clk_sys, and an
 * Avalon-MM master that holds each request until waitrequest is seen low.
 */
`timescale 1ns/100ps

module obcc_loader (
	input wire logic clk_sys, // System clock, 100 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic nv_init, // Loads the shipped option contents.
	input wire logic prog_mode, // Programming mode pin, asynchronous.
	input wire logic halt_exit, // One-cycle pulse when leaving Halt mode.
	input wire logic [4:0] avs_address, // Byte address.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [31:0] avs_writedata, // Write data.
	input wire logic [3:0] avs_byteenable, // Byte enables.
	output logic [31:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Stall, high until the answer.
	output obcc_pkg::obcc_cfg_t clk_cfg, // Decoded configuration.
	output logic clk_stable // Stabilisation count has elapsed.
);
	import obcc_pkg::*;

	obcc_state_t state;
	obcc_state_t next_state;
	logic req;
	logic take;
	logic [7:0] rd_byte;

	// ****************************************************************
	// Decode of the option bytes
	// ****************************************************************
	function automatic obcc_cfg_t decode(input logic [7:0] oc, input logic [7:0] orv,
			input logic [7:0] op);
		obcc_cfg_t c;
		logic [2:0] rng;
		rng = oc[OBCC_RANGE_MSB:OBCC_RANGE_LSB];
		c.rc_on = ~oc[OBCC_INTERNAL_RC_DISABLE];
		c.resonator_en = ~c.rc_on & ~rng[2];
		c.resonator_range = c.resonator_en ? rng[1:0] : 2'h0;
		c.ext_clk = ~c.rc_on & rng[2] & rng[1];
		c.range_reserved = ~c.rc_on & (rng == OBCC_RANGE_RSVD_A || rng == OBCC_RANGE_RSVD_B);
		c.mult_en = ~oc[OBCC_MULTIPLIER_BYPASS];
		c.mult_x8 = oc[OBCC_MULTIPLIER_FACTOR_SELECT];
		c.halving_en = ~oc[OBCC_HALVING_DISABLE];
		c.package_code = op[OBCC_PACKAGE_MSB] ? OBCC_PKG_48 :
			(op[OBCC_PACKAGE_LSB] ? OBCC_PKG_44 : OBCC_PKG_32);
		c.slave3_en = ~op[OBCC_TRIPLE_ADDRESS_SLAVE_SELECT];
		c.combo_error = ~c.mult_en | (c.halving_en & ~c.mult_x8) | (orv != 8'hff) |
			(op[4:0] != OBCC_PKG_RSVD_ONES);
		return c;
	endfunction

	assign req = avs_read | avs_write;
	assign take = req & ~state.waitreq;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_state = state;
		rd_byte = 8'h00;
		next_state.prog_meta = prog_mode;
		next_state.prog_sync = state.prog_meta;
		// Each request is answered on the second edge after it rises.
		next_state.waitreq = ~(req & state.waitreq);
		case (avs_address)
			OBCC_ADDR_CLK_OPT: rd_byte = state.prog_sync ? state.opt_clk : 8'h00;
			OBCC_ADDR_RSVD_OPT: rd_byte = state.prog_sync ? state.opt_rsvd : 8'h00;
			OBCC_ADDR_PKG_OPT: rd_byte = state.prog_sync ? state.opt_pkg : 8'h00;
			default: rd_byte = 8'h00;
		endcase
		if (req && state.waitreq) begin
			if (avs_address == OBCC_ADDR_STATUS) begin
				next_state.rdata = {16'h0000, state.prog_sync, state.stable,
					state.stab_long, state.cfg};
			end else begin
				next_state.rdata = {24'h000000, rd_byte};
			end
		end
		if (take && avs_write && avs_byteenable[0] && state.prog_sync) begin
			case (avs_address)
				OBCC_ADDR_CLK_OPT: next_state.opt_clk = avs_writedata[7:0];
				OBCC_ADDR_RSVD_OPT: next_state.opt_rsvd = avs_writedata[7:0];
				OBCC_ADDR_PKG_OPT: next_state.opt_pkg = avs_writedata[7:0];
				default: next_state.opt_clk = state.opt_clk;
			endcase
		end
		if (halt_exit) begin
			next_state.stable = 1'b0;
			next_state.stab_cnt = (state.stab_long ? OBCC_STAB_LONG : OBCC_STAB_SHORT) -
				13'h0001;
		end else if (!state.stable) begin
			if (state.stab_cnt == 13'h0000) begin
				next_state.stable = 1'b1;
			end else begin
				next_state.stab_cnt = state.stab_cnt - 13'h0001;
			end
		end
		if (nv_init) begin
			next_state.opt_clk = OBCC_CLK_OPT_RESET;
			next_state.opt_rsvd = OBCC_RSVD_OPT_RESET;
			next_state.opt_pkg = OBCC_PKG_OPT_RESET;
		end
		if (rst) begin
			next_state.prog_meta = 1'b0;
			next_state.prog_sync = 1'b0;
			next_state.waitreq = 1'b1;
			next_state.rdata = 32'h00000000;
			next_state.cfg = decode(next_state.opt_clk, next_state.opt_rsvd,
				next_state.opt_pkg);
			next_state.stab_long = ~next_state.opt_clk[OBCC_RESET_DELAY_SELECT];
			next_state.stab_cnt = (next_state.stab_long ? OBCC_STAB_LONG : OBCC_STAB_SHORT) -
				13'h0001;
			next_state.stable = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		state <= next_state;
	end

	assign avs_readdata = state.rdata;
	assign avs_waitrequest = state.waitreq;
	assign clk_cfg = state.cfg;
	assign clk_stable = state.stable;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	logic [12:0] low_cnt;

	always_ff @(posedge clk_sys) begin
		if (rst || halt_exit) begin
			low_cnt <= 13'h0000;
		end else if (!state.stable) begin
			low_cnt <= low_cnt + 13'h0001;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	stab_length_a: assert property ($rose(state.stable) |->
		low_cnt == (state.stab_long ? OBCC_STAB_LONG : OBCC_STAB_SHORT))
		else $error("Stabilisation count has the wrong length.");
	stable_hold_a: assert property (state.stable && !halt_exit |=> state.stable)
		else $error("Stable flag dropped without a restart.");
	rc_gate_a: assert property (state.cfg.rc_on |->
		!state.cfg.resonator_en && !state.cfg.ext_clk && !state.cfg.range_reserved)
		else $error("Range field acts while the RC oscillator is on.");
	range_code_a: assert property ($fell(rst) && !state.cfg.rc_on |->
		state.cfg.ext_clk == (state.opt_clk[6:5] == 2'h3) &&
		state.cfg.resonator_en == !state.opt_clk[6])
		else $error("Range field decoded wrongly.");
	range_rsvd_a: assert property ($fell(rst) |->
		state.cfg.range_reserved == (!state.cfg.rc_on && state.opt_clk[6:5] == 2'h2))
		else $error("Reserved range code decoded wrongly.");
	rc_select_a: assert property ($fell(rst) |->
		state.cfg.rc_on == !state.opt_clk[OBCC_INTERNAL_RC_DISABLE])
		else $error("RC oscillator enable decoded wrongly.");
	mult_bits_a: assert property ($fell(rst) |->
		{state.cfg.mult_en, state.cfg.mult_x8, state.cfg.halving_en} == {~state.opt_clk[0],
		state.opt_clk[1], ~state.opt_clk[2]})
		else $error("Multiplier settings decoded wrongly.");
	combo_flag_a: assert property ($fell(rst) |->
		state.cfg.combo_error == (state.opt_clk[0] | (!state.opt_clk[2] & !state.opt_clk[1]) |
		(state.opt_rsvd != OBCC_RSVD_OPT_RESET) |
		(state.opt_pkg[4:0] != OBCC_PKG_RSVD_ONES)))
		else $error("Invalid option combination not flagged.");
	package_code_a: assert property ($fell(rst) |->
		state.cfg.package_code == (state.opt_pkg[7] ? OBCC_PKG_48 : {1'b0, state.opt_pkg[6]}))
		else $error("Package selection decoded wrongly.");
	slave_sel_a: assert property ($fell(rst) |->
		state.cfg.slave3_en == !state.opt_pkg[OBCC_TRIPLE_ADDRESS_SLAVE_SELECT])
		else $error("Slave select decoded wrongly.");
	write_gate_a: assert property (avs_write && !state.waitreq && !state.prog_sync &&
		!nv_init |=> $stable(state.opt_clk) && $stable(state.opt_pkg) &&
		$stable(state.opt_rsvd))
		else $error("Option byte written outside programming mode.");
	cfg_hold_a: assert property (!$past(rst) |-> $stable(state.cfg))
		else $error("Decoded configuration changed without reset.");
	answer_time_a: assert property ($rose(req) && state.waitreq |=>
		!state.waitreq ##1 state.waitreq)
		else $error("Bus answer not on the second edge.");

	long_stab_c: cover property ($rose(state.stable) && state.stab_long);
	halt_exit_c: cover property (halt_exit ##[1:300] $rose(state.stable));
	prog_write_c: cover property (avs_write && !state.waitreq && state.prog_sync);
	ext_clk_c: cover property (state.cfg.ext_clk);
	slave_on_c: cover property (state.cfg.slave3_en);

endmodule

// ---- test/obcc_loader_bench.sv ----
/*
 * Self-checking bench for the option byte clock configuration loader.
 * Assumes obcc_pkg and obcc_loader are compiled first; the bench drives every port itself.
 */
`timescale 1ns/100ps

module obcc_loader_bench;
	import obcc_pkg::*;
	logic clk_sys, rst, nv_init, prog_mode, halt_exit, avs_read, avs_write;
	logic avs_waitrequest, clk_stable;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	obcc_cfg_t clk_cfg, exp_cfg, mask, hold;
	logic [7:0] b_clk, b_rsvd, b_pkg;
	integer seed = 17, n_fail = 0, tests_run = 0, n, i;

	obcc_loader dut (.clk_sys(clk_sys), .rst(rst), .nv_init(nv_init), .prog_mode(prog_mode),
		.halt_exit(halt_exit), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .clk_cfg(clk_cfg),
		.clk_stable(clk_stable));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ****************************************************************
	// Checking and closing
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#900000;
		n_fail++;
		report_and_stop;
	end

	// ****************************************************************
	// Expectations
	// ****************************************************************
	function automatic obcc_cfg_t expect_cfg(input logic [7:0] c, input logic [7:0] r,
		input logic [7:0] p);
		obcc_cfg_t e;
		e = '0;
		e.rc_on = ~c[3];
		if (c[3]) begin
			e.resonator_en = ~c[6];
			e.resonator_range = c[5:4];
			e.range_reserved = c[6] & ~c[5];
			e.ext_clk = c[6] & c[5];
		end
		e.mult_en = ~c[0];
		e.mult_x8 = c[1];
		e.halving_en = ~c[2];
		e.package_code = p[7] ? OBCC_PKG_48 : {1'b0, p[6]};
		e.slave3_en = ~p[5];
		e.combo_error = c[0] | (~c[2] & ~c[1]) | (r != 8'hff) | (p[4:0] != OBCC_PKG_RSVD_ONES);
		return e;
	endfunction

	// The range code is only meaningful while a resonator is in use.
	task automatic check_cfg;
		exp_cfg = expect_cfg(b_clk, b_rsvd, b_pkg);
		mask = '1;
		mask.resonator_range = {2{exp_cfg.resonator_en}};
		check(32'(clk_cfg & mask), 32'(exp_cfg & mask));
	endtask

	// ****************************************************************
	// Drivers
	// ****************************************************************
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] be);
		integer k;
		logic w;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {8'($random(seed)), 16'h0000, d};
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		k = 0;
		// Registered answers are read mid-cycle, so the edge that follows is the one they meet.
		do begin
			@(negedge clk_sys);
			k++;
			w = avs_waitrequest;
			rd = avs_readdata;
			@(posedge clk_sys);
		end while (w !== 1'b0);
		// The answer stands in the cycle after the request is first seen.
		check(k, 32'h2);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Counts edges after the one that sampled the cause until the stable flag is seen.
	task automatic wait_stable(input logic [7:0] c);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			#1;
		end while (clk_stable !== 1'b1 && n < 5000);
		check(n, c[7] ? 32'(OBCC_STAB_SHORT) : 32'(OBCC_STAB_LONG));
	endtask

	task automatic do_reset(input logic init);
		@(posedge clk_sys);
		rst <= 1'b1;
		nv_init <= init;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		nv_init <= 1'b0;
		wait_stable(b_clk);
		check_cfg;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{rst, nv_init, prog_mode, halt_exit, avs_read, avs_write} = 6'h30;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		b_clk = OBCC_CLK_OPT_RESET;
		b_rsvd = OBCC_RSVD_OPT_RESET;
		b_pkg = OBCC_PKG_OPT_RESET;
		do_reset(1'b1);
		bus(1'b0, OBCC_ADDR_CLK_OPT, 8'h00, 4'hf);
		check(rd, 32'h0);
		bus(1'b1, OBCC_ADDR_CLK_OPT, 8'h00, 4'hf);
		@(posedge clk_sys);
		prog_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bus(1'b0, OBCC_ADDR_STATUS, 8'h00, 4'hf);
		check(32'(rd[15:13]), 32'h6);
		bus(1'b1, OBCC_ADDR_CLK_OPT, 8'h00, 4'he);
		bus(1'b0, OBCC_ADDR_CLK_OPT, 8'h00, 4'hf);
		check(rd, 32'(b_clk));
		bus(1'b0, 5'h10, 8'h00, 4'hf);
		check(rd, 32'h0);
		for (i = 0; i < 10; i++) begin
			hold = clk_cfg;
			b_clk = 8'($random(seed));
			if (i < 8) begin
				b_clk[6:3] = {i[2:0], 1'b1};
			end
			if (i < 4) begin
				b_clk[7] = 1'b0;
				b_clk[2:0] = (b_clk[2:1] == 2'h0) ? 3'h4 : {b_clk[2:1], 1'b0};
			end
			b_pkg = (i == 8) ? 8'($random(seed)) : {3'($random(seed)), 5'h1f};
			b_rsvd = (i == 9) ? 8'h7f : 8'hff;
			bus(1'b1, OBCC_ADDR_CLK_OPT, b_clk, 4'hf);
			bus(1'b1, OBCC_ADDR_RSVD_OPT, b_rsvd, 4'hf);
			bus(1'b1, OBCC_ADDR_PKG_OPT, b_pkg, 4'hf);
			bus(1'b0, OBCC_ADDR_PKG_OPT, 8'h00, 4'hf);
			check(rd, 32'(b_pkg));
			check(32'(clk_cfg), 32'(hold));
			do_reset(1'b0);
		end
		@(posedge clk_sys);
		halt_exit <= 1'b1;
		@(posedge clk_sys);
		halt_exit <= 1'b0;
		wait_stable(b_clk);
		report_and_stop;
	end
endmodule
